// *** logic/dout_pkg.sv ***
// Package with constants for the discrete output channel logic
package dout_pkg;
    localparam int NUM_CHANNELS = 64;
    localparam int GROUP_SIZE = 8;
    localparam int NUM_GROUPS = NUM_CHANNELS / GROUP_SIZE;
    localparam int HALF_SIZE = 32;
    localparam int TASK_GROUP_SIZE = 8;
    localparam int NUM_TASK_GROUPS = NUM_CHANNELS / TASK_GROUP_SIZE;
    localparam int CLOCK_HZ = 100_000_000;
    localparam int REACT_SPACING_S = 10;
    localparam longint REACT_CYCLES = longint'(REACT_SPACING_S) * longint'(CLOCK_HZ);
    localparam int FLASH_HALF_MS = 250;
    localparam longint FLASH_CYCLES = longint'(FLASH_HALF_MS) * longint'(CLOCK_HZ) / 1000;
    localparam int ADDR_W = 4;
    // Register offsets (32-bit word addresses)
    localparam logic [3:0] ADDR_CMD_LO = 4'h0;
    localparam logic [3:0] ADDR_CMD_HI = 4'h1;
    localparam logic [3:0] ADDR_CONFIG = 4'h2;
    localparam logic [3:0] ADDR_REACT = 4'h3;
    localparam logic [3:0] ADDR_TRIP_LO = 4'h4;
    localparam logic [3:0] ADDR_TRIP_HI = 4'h5;
    localparam logic [3:0] ADDR_IRQ_STATUS = 4'h6;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h7;
    localparam logic [3:0] ADDR_STATE = 4'h8;
    // Config register fields
    localparam int CFG_AUTO_BIT = 0;
    localparam int CFG_MAINTAIN_BIT = 1;
    localparam int CFG_RUNSTOP_EN_BIT = 2;
    localparam int CFG_FALLBACK_LSB = 8;
    localparam int CFG_TASK_LSB = 16;
    localparam int CFG_RUNSTOP_SEL_LSB = 24;
    // Interrupt status bits
    localparam int IRQ_TRIP_BIT = 0;
    localparam int IRQ_REACT_BIT = 1;
    localparam int IRQ_STOP_BIT = 2;
    localparam int IRQ_FALLBACK_BIT = 3;
    localparam int IRQ_W = 4;
    localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
endpackage : dout_pkg

// *** logic/flash_timer.sv ***
// Free running blink generator for the indicators
`timescale 1ns/1ps
module flash_timer #(
    parameter longint HALF_CYCLES = 25_000_000
) (
    input wire logic i_clock,
    input wire logic i_resetn,
    output logic o_blink
);
    localparam int CW = $clog2(HALF_CYCLES + 1);
    logic [CW-1:0] count_reg;

    initial begin
        if (HALF_CYCLES < 1) begin
            $error("flash_timer: HALF_CYCLES must be at least 1");
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            count_reg <= '0;
            o_blink <= 1'b0;
        end else if (count_reg == CW'(HALF_CYCLES - 1)) begin
            count_reg <= '0;
            o_blink <= ~o_blink;
        end else begin
            count_reg <= count_reg + 1'b1;
        end
    end
endmodule : flash_timer

// *** logic/discrete_output_protect_fallback.sv ***
// Channel control of a protected discrete output module
//
// Added by the designer: the register offsets and strobed register access.
`timescale 1ns/1ps
module discrete_output_protect_fallback
    import dout_pkg::*;
#(
    parameter int CHANNELS = dout_pkg::NUM_CHANNELS,
    parameter longint REACT_SPACING_CYCLES = dout_pkg::REACT_CYCLES,
    parameter longint FLASH_HALF_CYCLES = dout_pkg::FLASH_CYCLES
) (
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic [dout_pkg::ADDR_W-1:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire logic [dout_pkg::NUM_CHANNELS-1:0] i_overload,
    input wire logic i_terminal_fault,
    input wire logic i_processor_fault,
    input wire logic i_rack_fault,
    input wire logic i_cable_fault,
    input wire logic i_internal_fault,
    input wire logic i_exchange_fault,
    input wire logic [dout_pkg::NUM_CHANNELS-1:0] i_inputs,
    input wire logic i_remote_run,
    input wire logic i_remote_stop,
    input wire logic i_pushbutton,
    output logic [dout_pkg::NUM_CHANNELS-1:0] o_outputs,
    output logic [dout_pkg::HALF_SIZE-1:0] o_channel_led,
    output logic o_io_fault_led,
    output logic o_error_led,
    output logic o_half_led,
    output logic o_plc_run,
    output logic [dout_pkg::NUM_TASK_GROUPS-1:0] o_task_fast,
    output logic o_irq
);
    import dout_pkg::*;

    localparam int NG = CHANNELS / GROUP_SIZE;
    localparam int TW = $clog2(REACT_SPACING_CYCLES + 1);

    initial begin
        if (CHANNELS != NUM_CHANNELS) begin
            $error("CHANNELS must equal 64 for this register map");
        end
        if (REACT_SPACING_CYCLES < 1) begin
            $error("REACT_SPACING_CYCLES must be at least 1");
        end
    end

    typedef enum logic [1:0] {
        RS_STOP = 2'b00,
        RS_RUN = 2'b01,
        RS_FALLBACK = 2'b11
    } plc_state_e;

    // ==================================================
    // Input synchronisers
    // ==================================================
    logic [CHANNELS-1:0] ovl_meta_reg, ovl_reg;
    logic [CHANNELS-1:0] in_meta_reg, in_reg;
    logic [7:0] misc_meta_reg, misc_reg;
    logic button_prev_reg, sel_prev_reg;

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            ovl_meta_reg <= '0;
            ovl_reg <= '0;
            in_meta_reg <= '0;
            in_reg <= '0;
            misc_meta_reg <= '0;
            misc_reg <= '0;
        end else begin
            ovl_meta_reg <= i_overload;
            ovl_reg <= ovl_meta_reg;
            in_meta_reg <= i_inputs;
            in_reg <= in_meta_reg;
            misc_meta_reg <= {i_pushbutton, i_exchange_fault, i_internal_fault, i_cable_fault,
                              i_rack_fault, i_processor_fault, i_terminal_fault, 1'b0};
            misc_reg <= misc_meta_reg;
        end
    end

    logic term_fault, stop_fault, int_fault, xchg_fault, button;
    assign term_fault = misc_reg[1];
    assign stop_fault = misc_reg[2] | misc_reg[3] | misc_reg[4];
    assign int_fault = misc_reg[5];
    assign xchg_fault = misc_reg[6];
    assign button = misc_reg[7];

    // ==================================================
    // Register file
    // ==================================================
    logic [CHANNELS-1:0] cmd_reg, trip_reg, held_reg;
    logic [31:0] config_reg;
    logic [IRQ_W-1:0] irq_status_reg, irq_mask_reg, irq_set;
    logic [NG-1:0] react_req_reg;
    plc_state_e state_reg;
    logic [TW-1:0] spacing_reg;
    logic half_reg;

    function automatic logic wr_hit(input logic [ADDR_W-1:0] a);
        wr_hit = i_wr && (i_addr == a);
    endfunction : wr_hit

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            cmd_reg <= '0;
        end else begin
            if (wr_hit(ADDR_CMD_LO)) begin
                cmd_reg[31:0] <= i_wdata;
            end
            if (wr_hit(ADDR_CMD_HI)) begin
                cmd_reg[63:32] <= i_wdata;
            end
        end
    end

    // Policy and fallback values, writable except while in fallback
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            config_reg <= CONFIG_RESET;
        end else if (wr_hit(ADDR_CONFIG) && state_reg != RS_FALLBACK) begin
            config_reg <= i_wdata;
        end
    end

    logic auto_mode, maintain_mode, runstop_en;
    logic [NG-1:0] fallback_val;
    logic [5:0] runstop_sel;
    assign auto_mode = config_reg[CFG_AUTO_BIT];
    assign maintain_mode = config_reg[CFG_MAINTAIN_BIT];
    assign runstop_en = config_reg[CFG_RUNSTOP_EN_BIT];
    assign fallback_val = config_reg[CFG_FALLBACK_LSB +: NG];
    assign runstop_sel = config_reg[CFG_RUNSTOP_SEL_LSB +: 6];

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_task_fast <= '0;
        end else begin
            o_task_fast <= config_reg[CFG_TASK_LSB +: NUM_TASK_GROUPS];
        end
    end

    // ==================================================
    // Reactivation requests and spacing timer
    // ==================================================
    logic spacing_done, react_fire;
    logic [NG-1:0] react_groups;
    assign spacing_done = (spacing_reg == '0);
    assign react_groups = auto_mode ? {NG{1'b1}} : react_req_reg;
    assign react_fire = spacing_done && !term_fault && (|react_groups);

    // Programmed requests wait until spacing elapses
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            react_req_reg <= '0;
        end else if (react_fire) begin
            react_req_reg <= wr_hit(ADDR_REACT) ? i_wdata[NG-1:0] : '0;
        end else if (wr_hit(ADDR_REACT)) begin
            react_req_reg <= react_req_reg | i_wdata[NG-1:0];
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            spacing_reg <= '0;
        end else if (react_fire) begin
            spacing_reg <= TW'(REACT_SPACING_CYCLES - 1);
        end else if (!spacing_done) begin
            spacing_reg <= spacing_reg - 1'b1;
        end
    end

    // ==================================================
    // Trip flags
    // ==================================================
    logic [CHANNELS-1:0] react_mask, trip_new;
    always_comb begin
        react_mask = '0;
        for (int g = 0; g < NG; g++) begin
            if (react_fire && react_groups[g]) begin
                react_mask[g*GROUP_SIZE +: GROUP_SIZE] = {GROUP_SIZE{1'b1}};
            end
        end
    end
    assign trip_new = ovl_reg & o_outputs & ~trip_reg;

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            trip_reg <= '0;
        end else begin
            // Only commanded channels of reactivated groups are cleared; a new overload wins
            trip_reg <= (trip_reg & ~(react_mask & cmd_reg)) | (ovl_reg & o_outputs);
        end
    end

    // ==================================================
    // Run/stop control
    // ==================================================
    logic rs_input, rs_rise;
    assign rs_input = in_reg[runstop_sel];
    assign rs_rise = runstop_en && rs_input && !sel_prev_reg;

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            sel_prev_reg <= 1'b0;
            button_prev_reg <= 1'b0;
        end else begin
            sel_prev_reg <= rs_input;
            button_prev_reg <= button;
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            state_reg <= RS_STOP;
        end else begin
            case (state_reg)
                RS_STOP: begin
                    if (stop_fault) begin
                        state_reg <= RS_STOP;
                    end else if (rs_rise || i_remote_run) begin
                        state_reg <= RS_RUN;
                    end
                end
                RS_RUN: begin
                    if (stop_fault) begin
                        state_reg <= RS_FALLBACK;
                    end else if ((rs_rise && runstop_en) || i_remote_stop) begin
                        state_reg <= RS_STOP;
                    end
                end
                RS_FALLBACK: begin
                    if (!stop_fault && i_remote_run && !rs_rise) begin
                        state_reg <= RS_RUN;
                    end
                end
                default: state_reg <= RS_STOP;
            endcase
        end
    end

    // Input stop: a rising edge while running stops; in fallback, a run request
    // in the same cycle as an input edge is refused
    logic input_stop_now;
    assign input_stop_now = rs_rise && state_reg == RS_RUN;

    // ==================================================
    // Output drive
    // ==================================================
    logic [CHANNELS-1:0] fb_vector, out_next;
    always_comb begin
        for (int g = 0; g < NG; g++) begin
            fb_vector[g*GROUP_SIZE +: GROUP_SIZE] = {GROUP_SIZE{fallback_val[g]}};
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            held_reg <= '0;
        end else if (state_reg == RS_RUN) begin
            held_reg <= o_outputs;
        end
    end

    always_comb begin
        if (state_reg == RS_FALLBACK) begin
            out_next = maintain_mode ? held_reg : fb_vector;
        end else if (state_reg == RS_RUN) begin
            out_next = cmd_reg;
        end else begin
            out_next = '0;
        end
        out_next = out_next & ~trip_reg & ~trip_new;
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_outputs <= '0;
        end else begin
            o_outputs <= out_next;
        end
    end

    // ==================================================
    // Indicators
    // ==================================================
    logic blink;
    flash_timer #(
        .HALF_CYCLES(FLASH_HALF_CYCLES)
    ) u_flash (
        .i_clock(i_clock),
        .i_resetn(i_resetn),
        .o_blink(blink)
    );

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            half_reg <= 1'b0;
        end else if (button && !button_prev_reg) begin
            half_reg <= ~half_reg;
        end
    end

    logic [HALF_SIZE-1:0] shown_state, shown_trip;
    assign shown_state = half_reg ? o_outputs[63:32] : o_outputs[31:0];
    assign shown_trip = half_reg ? trip_reg[63:32] : trip_reg[31:0];

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_channel_led <= '0;
            o_io_fault_led <= 1'b0;
            o_error_led <= 1'b0;
            o_half_led <= 1'b0;
            o_plc_run <= 1'b0;
        end else begin
            o_channel_led <= (shown_state & ~shown_trip) | (shown_trip & {HALF_SIZE{blink}});
            o_io_fault_led <= (|trip_reg) | term_fault;
            o_error_led <= int_fault | (xchg_fault & blink);
            o_half_led <= half_reg;
            o_plc_run <= (state_reg == RS_RUN) && !input_stop_now;
        end
    end

    // ==================================================
    // Interrupts and read path
    // ==================================================
    assign irq_set[IRQ_TRIP_BIT] = |trip_new;
    assign irq_set[IRQ_REACT_BIT] = react_fire;
    assign irq_set[IRQ_STOP_BIT] = input_stop_now;
    assign irq_set[IRQ_FALLBACK_BIT] = (state_reg == RS_RUN) && stop_fault;

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            irq_status_reg <= '0;
            irq_mask_reg <= '0;
            o_irq <= 1'b0;
        end else begin
            irq_status_reg <= (irq_status_reg & ~(wr_hit(ADDR_IRQ_STATUS) ? i_wdata[IRQ_W-1:0] : '0)) | irq_set;
            if (wr_hit(ADDR_IRQ_MASK)) begin
                irq_mask_reg <= i_wdata[IRQ_W-1:0];
            end
            o_irq <= |(irq_status_reg & irq_mask_reg);
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rdata <= '0;
        end else if (i_rd) begin
            case (i_addr)
                ADDR_CMD_LO: o_rdata <= cmd_reg[31:0];
                ADDR_CMD_HI: o_rdata <= cmd_reg[63:32];
                ADDR_CONFIG: o_rdata <= config_reg;
                ADDR_REACT: o_rdata <= {{(32-NG){1'b0}}, react_req_reg};
                ADDR_TRIP_LO: o_rdata <= trip_reg[31:0];
                ADDR_TRIP_HI: o_rdata <= trip_reg[63:32];
                ADDR_IRQ_STATUS: o_rdata <= {{(32-IRQ_W){1'b0}}, irq_status_reg};
                ADDR_IRQ_MASK: o_rdata <= {{(32-IRQ_W){1'b0}}, irq_mask_reg};
                ADDR_STATE: o_rdata <= {27'h0, spacing_done, half_reg, term_fault, state_reg};
                default: o_rdata <= 32'h0000_0000;
            endcase
        end else begin
            o_rdata <= 32'h0000_0000;
        end
    end
endmodule : discrete_output_protect_fallback

// *** sim/dout_checker_properties.sv ***
// Port-level checks for the discrete output channel block
`timescale 1ns/1ps
module dout_checker
    import dout_pkg::*;
#(
    parameter int CHANNELS = 64,
    parameter longint REACT_SPACING_CYCLES = 100,
    parameter longint FLASH_HALF_CYCLES = 4
) (
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic i_wr,
    input wire logic [dout_pkg::NUM_CHANNELS-1:0] i_overload,
    input wire logic i_terminal_fault,
    input wire logic i_processor_fault,
    input wire logic i_rack_fault,
    input wire logic i_cable_fault,
    input wire logic i_internal_fault,
    input wire logic i_exchange_fault,
    input wire logic i_pushbutton,
    input wire logic [dout_pkg::NUM_CHANNELS-1:0] o_outputs,
    input wire logic o_io_fault_led,
    input wire logic o_error_led,
    input wire logic o_half_led,
    input wire logic o_plc_run,
    input wire logic [dout_pkg::NUM_TASK_GROUPS-1:0] o_task_fast
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_resetn);
    // ==========
    // Assertions
    AST_TRIP_OFF: assert property ((o_outputs[3] && i_overload[3]) [*5] |=> !o_outputs[3])
        else $error("channel kept on under overload");
    AST_IO_LED: assert property (i_terminal_fault [*4] |-> o_io_fault_led)
        else $error("fault led dark during terminal fault");
    AST_STOP_FAULT: assert property ((i_processor_fault || i_rack_fault || i_cable_fault) [*5] |-> !o_plc_run)
        else $error("run kept during stop fault");
    AST_HALF_TOGGLE: assert property ($rose(i_pushbutton) |-> ##[1:6] $changed(o_half_led))
        else $error("half not toggled by press");
    AST_HALF_HOLD: assert property (!i_pushbutton [*6] |-> $stable(o_half_led))
        else $error("half changed without press");
    AST_ERR_STEADY: assert property (i_internal_fault [*4] |-> o_error_led)
        else $error("error led dark on internal fault");
    AST_ERR_DARK: assert property ((!i_internal_fault && !i_exchange_fault) [*4] |-> !o_error_led)
        else $error("error led lit without fault");
    AST_TASK_HOLD: assert property (!$past(i_wr) && !$past(i_wr, 2) |-> $stable(o_task_fast))
        else $error("task groups changed without write");
endmodule : dout_checker

bind discrete_output_protect_fallback dout_checker #(.CHANNELS(CHANNELS),
    .REACT_SPACING_CYCLES(REACT_SPACING_CYCLES), .FLASH_HALF_CYCLES(FLASH_HALF_CYCLES)) chk (.i_clock, .i_resetn,
    .i_wr, .i_overload, .i_terminal_fault, .i_processor_fault, .i_rack_fault, .i_cable_fault, .i_internal_fault,
    .i_exchange_fault, .i_pushbutton, .o_outputs, .o_io_fault_led, .o_error_led, .o_half_led, .o_plc_run,
    .o_task_fast);

// *** sim/processor_model.sv ***
// Processor side of the backplane: register bus and run/stop requests
`timescale 1ns/1ps
module processor_model
    import dout_pkg::*;
(
    input wire logic i_clock,
    input wire logic [31:0] i_rdata,
    output logic [dout_pkg::ADDR_W-1:0] o_addr,
    output logic [31:0] o_wdata,
    output logic o_wr,
    output logic o_rd,
    output logic o_remote_run,
    output logic o_remote_stop
);
    initial begin
        o_addr = '0;
        o_wdata = '0;
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_remote_run = 1'b0;
        o_remote_stop = 1'b0;
    end
    // ==========
    // Bus cycles
    task automatic wr(input logic [ADDR_W-1:0] addr, input logic [31:0] data);
        @(posedge i_clock);
        o_addr <= addr;
        o_wdata <= data;
        o_wr <= 1'b1;
        @(posedge i_clock);
        o_wr <= 1'b0;
        o_wdata <= ~data;
        o_addr <= ~addr;
    endtask : wr
    task automatic rd(input logic [ADDR_W-1:0] addr, output logic [31:0] data);
        @(posedge i_clock);
        o_addr <= addr;
        o_rd <= 1'b1;
        @(posedge i_clock);
        o_rd <= 1'b0;
        o_addr <= ~addr;
        #1;
        data = i_rdata;
    endtask : rd
    // ==========
    // Run and stop requests
    task automatic request(input logic run);
        @(posedge i_clock);
        o_remote_run <= run;
        o_remote_stop <= !run;
        @(posedge i_clock);
        o_remote_run <= 1'b0;
        o_remote_stop <= 1'b0;
    endtask : request
endmodule : processor_model

// *** sim/discrete_output_protect_fallback_tb.sv ***
// Self-checking bench for the discrete output channel block
`timescale 1ns/1ps
module discrete_output_protect_fallback_tb;
    import dout_pkg::*;
    localparam logic [63:0] RUNV = 64'h9abcdef0_12345658;
    localparam logic [63:0] FBV = 64'hff00ff00_00ff00df;
    logic i_clock = 1'b0;
    logic i_resetn = 1'b0;
    logic [ADDR_W-1:0] i_addr;
    logic [31:0] i_wdata;
    logic [31:0] o_rdata;
    logic i_wr, i_rd, i_remote_run, i_remote_stop;
    logic [63:0] i_overload, i_inputs, o_outputs;
    logic i_terminal_fault, i_processor_fault, i_rack_fault, i_cable_fault;
    logic i_internal_fault, i_exchange_fault, i_pushbutton;
    logic [31:0] o_channel_led;
    logic o_io_fault_led, o_error_led, o_half_led, o_plc_run, o_irq;
    logic [7:0] o_task_fast;
    int n_errors = 0;
    int check_count = 0;
    processor_model proc (.i_clock(i_clock), .i_rdata(o_rdata), .o_addr(i_addr), .o_wdata(i_wdata),
        .o_wr(i_wr), .o_rd(i_rd), .o_remote_run(i_remote_run), .o_remote_stop(i_remote_stop));
    discrete_output_protect_fallback #(.REACT_SPACING_CYCLES(100), .FLASH_HALF_CYCLES(4)) uut (.i_clock,
        .i_resetn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_overload, .i_terminal_fault, .i_processor_fault,
        .i_rack_fault, .i_cable_fault, .i_internal_fault, .i_exchange_fault, .i_inputs, .i_remote_run,
        .i_remote_stop, .i_pushbutton, .o_outputs, .o_channel_led, .o_io_fault_led, .o_error_led, .o_half_led,
        .o_plc_run, .o_task_fast, .o_irq);
    initial begin
        forever #5 i_clock = ~i_clock;
    end
    // ==========
    // Helpers
    task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s: expected %h, seen %h", name, exp, got);
        end
    endtask : chk
    task automatic settle(input int n);
        repeat (n) @(posedge i_clock);
        @(negedge i_clock);
    endtask : settle
    task automatic rd_chk(input string name, input logic [ADDR_W-1:0] addr, input logic [31:0] exp);
        logic [31:0] d;
        proc.rd(addr, d);
        chk(name, {32'h0, exp}, {32'h0, d});
    endtask : rd_chk
    task automatic wait_trip(input logic [31:0] exp, input int tries);
        logic [31:0] d;
        for (int k = 0; k < tries; k++) begin
            proc.rd(ADDR_TRIP_LO, d);
            if (d === exp) break;
        end
        chk("trip flags", {32'h0, exp}, {32'h0, d});
    endtask : wait_trip
    task automatic overload(input logic [63:0] mask);
        @(posedge i_clock);
        i_overload <= mask;
        settle(6);
        @(posedge i_clock);
        i_overload <= '0;
        settle(4);
    endtask : overload
    task automatic blinks(input int which);
        logic [1:0] seen;
        seen = 2'b00;
        repeat (12) begin
            @(negedge i_clock);
            seen[which == 0 ? o_channel_led[3] : o_error_led] = 1'b1;
        end
        chk("blink", 64'h3, {62'h0, seen});
    endtask : blinks
    task automatic finish_test;
        $display("checks %0d, errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test
    // ==========
    // Scenarios
    task automatic t_latch;
        rd_chk("config", ADDR_CONFIG, CONFIG_RESET);
        proc.wr(4'hf, 32'hffff_ffff);
        rd_chk("unmapped", 4'hf, 32'h0);
        proc.wr(ADDR_CONFIG, 32'h00ff_a500);
        proc.wr(ADDR_CMD_LO, 32'h1234_5678);
        proc.wr(ADDR_CMD_HI, 32'h9abc_def0);
        settle(2);
        chk("stop outputs", 64'h0, o_outputs);
        chk("task groups", 64'hff, {56'h0, o_task_fast});
        proc.request(1'b1);
        settle(30);
        chk("latched", 64'h9abcdef0_12345678, o_outputs);
    endtask : t_latch
    task automatic t_trip;
        overload(64'h1028);
        chk("tripped", 64'h9abcdef0_12344650, o_outputs);
        chk("io led", 64'h1, {63'h0, o_io_fault_led});
        chk("led on", 64'h1, {63'h0, o_channel_led[4]});
        blinks(0);
        rd_chk("trip", ADDR_TRIP_LO, 32'h1028);
        chk("irq masked", 64'h0, {63'h0, o_irq});
        proc.wr(ADDR_IRQ_MASK, 32'hf);
        settle(2);
        chk("irq", 64'h1, {63'h0, o_irq});
        proc.wr(ADDR_IRQ_STATUS, 32'hf);
        settle(2);
        chk("irq clear", 64'h0, {63'h0, o_irq});
    endtask : t_trip
    task automatic t_react;
        proc.wr(ADDR_CMD_LO, 32'h1234_5658);
        @(posedge i_clock);
        i_terminal_fault <= 1'b1;
        settle(4);
        proc.wr(ADDR_REACT, 32'h1);
        settle(120);
        rd_chk("blocked", ADDR_TRIP_LO, 32'h1028);
        @(posedge i_clock);
        i_terminal_fault <= 1'b0;
        wait_trip(32'h1020, 10);
        chk("reactivated", 64'h9abcdef0_12344658, o_outputs);
        overload(64'h8);
        proc.wr(ADDR_REACT, 32'h1);
        settle(20);
        rd_chk("deferred", ADDR_TRIP_LO, 32'h1028);
        wait_trip(32'h1020, 60);
        rd_chk("status", ADDR_IRQ_STATUS, 32'h3);
        proc.wr(ADDR_IRQ_STATUS, 32'hf);
    endtask : t_react
    task automatic t_auto;
        proc.wr(ADDR_CONFIG, 32'h00ff_a501);
        @(posedge i_clock);
        i_overload <= 64'h8;
        settle(250);
        @(posedge i_clock);
        i_overload <= '0;
        wait_trip(32'h20, 80);
    endtask : t_auto
    task automatic t_runstop;
        proc.wr(ADDR_CONFIG, 32'h07ff_a505);
        proc.request(1'b0);
        settle(3);
        chk("remote stop", 64'h0, {o_outputs[62:0], o_plc_run});
        proc.request(1'b1);
        settle(3);
        chk("remote run", 64'h1, {63'h0, o_plc_run});
        @(posedge i_clock);
        i_inputs[7] <= 1'b1;
        settle(20);
        chk("input stop", 64'h0, {63'h0, o_plc_run});
        proc.request(1'b1);
        settle(8);
        chk("level ignored", 64'h1, {63'h0, o_plc_run});
        @(posedge i_clock);
        i_inputs[7] <= 1'b0;
        settle(3);
        @(posedge i_clock);
        i_inputs[7] <= 1'b1;
        @(posedge i_clock);
        proc.request(1'b1);
        settle(6);
        chk("stop wins", 64'h0, {63'h0, o_plc_run});
        rd_chk("stop event", ADDR_IRQ_STATUS, 32'h7);
        @(posedge i_clock);
        i_inputs[7] <= 1'b0;
        proc.request(1'b1);
        settle(4);
    endtask : t_runstop
    task automatic t_fallback;
        logic [31:0] cfg;
        for (int k = 0; k < 3; k++) begin
            cfg = (k == 0) ? 32'h07ff_a505 : 32'h07ff_a507;
            proc.wr(ADDR_CONFIG, cfg);
            @(posedge i_clock);
            {i_cable_fault, i_rack_fault, i_processor_fault} <= 3'(1 << k);
            settle(6);
            chk("fault stop", 64'h0, {63'h0, o_plc_run});
            chk("fallback out", (k == 0) ? FBV : RUNV, o_outputs);
            proc.wr(ADDR_CONFIG, 32'h0);
            rd_chk("config held", ADDR_CONFIG, cfg);
            @(posedge i_clock);
            {i_cable_fault, i_rack_fault, i_processor_fault} <= 3'b000;
            settle(4);
            proc.request(1'b1);
            settle(4);
            chk("resumed", RUNV, o_outputs);
        end
    endtask : t_fallback
    task automatic t_leds;
        for (int k = 0; k < 2; k++) begin
            @(posedge i_clock);
            i_pushbutton <= 1'b1;
            settle(8);
            @(posedge i_clock);
            i_pushbutton <= 1'b0;
            settle(4);
            chk("half led", 64'(k == 0), {63'h0, o_half_led});
            chk("shown", (k == 0) ? 64'h9abcdef0 : 64'h123456, {32'h0, o_channel_led} >> (8 * k));
        end
        @(posedge i_clock);
        i_internal_fault <= 1'b1;
        settle(4);
        chk("err steady", 64'h1, {63'h0, o_error_led});
        @(posedge i_clock);
        i_internal_fault <= 1'b0;
        i_exchange_fault <= 1'b1;
        settle(4);
        blinks(1);
    endtask : t_leds
    // ==========
    // Main sequence
    initial begin
        {i_overload, i_inputs, i_terminal_fault, i_processor_fault, i_rack_fault, i_cable_fault,
            i_internal_fault, i_exchange_fault, i_pushbutton} = '0;
        repeat (20) @(posedge i_clock);
        chk("reset out", 64'h0, o_outputs);
        i_resetn <= 1'b1;
        t_latch;
        t_trip;
        t_react;
        t_auto;
        t_runstop;
        t_fallback;
        t_leds;
        finish_test;
    end
    initial begin
        repeat (100000) @(posedge i_clock);
        n_errors++;
        finish_test;
    end
endmodule : discrete_output_protect_fallback_tb
